/* logic/ctcip_chan.sv */
// One counter/timer channel: control word, time constant, down-counter
`timescale 1ns/100ps
`include "ctcip_regs.svh"

module ctcip_chan
  import ctcip_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       trig_pin,
  input  wire logic       wr,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] count,
  output logic            tc_wait,
  output logic            int_en,
  output logic            zero_pulse
);

  ctcip_chan_st_t s_r;
  ctcip_chan_st_t s_nxt;
  logic           edge_hit;
  logic           dec;
  logic [7:0]     pre_end;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt    = s_r;
    edge_hit = 1'b0;
    dec      = 1'b0;
    pre_end  = s_r.ctl[`CTCIP_B_PRE] ? `CTCIP_PRE256_END : `CTCIP_PRE16_END;
    if (rst || clk_en) begin
      s_nxt.trig_s1 = trig_pin;
      s_nxt.trig_s2 = s_r.trig_s1;
      s_nxt.trig_d  = s_r.trig_s2;
      edge_hit = s_r.ctl[`CTCIP_B_EDGE] ? (s_r.trig_s2 & ~s_r.trig_d)
                                        : (~s_r.trig_s2 & s_r.trig_d);
      s_nxt.zero = 1'b0;
      if (rst) begin
        s_nxt.ctl     = `CTCIP_CTL_RST;
        s_nxt.run     = 1'b0;
        s_nxt.arm     = 1'b0;
        s_nxt.tc_wait = 1'b0;
        s_nxt.pre     = 8'h00;
      end else begin
        if (s_r.arm && edge_hit) begin
          s_nxt.arm = 1'b0;
          s_nxt.run = 1'b1;
        end
        if (s_r.run) begin
          if (s_r.ctl[`CTCIP_B_MODE]) begin
            dec = edge_hit;
          end else if (s_r.pre == pre_end) begin
            dec       = 1'b1;
            s_nxt.pre = 8'h00;
          end else begin
            s_nxt.pre = s_r.pre + 8'h01;
          end
        end
        if (dec) begin
          if (s_r.cnt == `CTCIP_CNT_LAST) begin
            s_nxt.cnt  = s_r.tc;
            s_nxt.zero = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt - 8'h01;
          end
        end
        if (wr) begin
          if (s_r.tc_wait) begin
            s_nxt.tc      = wr_data;
            s_nxt.tc_wait = 1'b0;
            if (!s_r.run) begin
              s_nxt.cnt = wr_data;
              s_nxt.pre = 8'h00;
              if (!s_r.ctl[`CTCIP_B_MODE] && s_r.ctl[`CTCIP_B_TRIG]) begin
                s_nxt.arm = 1'b1;
              end else begin
                s_nxt.run = 1'b1;
              end
            end
          end else if (wr_data[`CTCIP_B_CW]) begin
            s_nxt.ctl     = wr_data;
            s_nxt.tc_wait = wr_data[`CTCIP_B_TCF];
            if (wr_data[`CTCIP_B_SRST]) begin
              s_nxt.run = 1'b0;
              s_nxt.arm = 1'b0;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    s_r <= s_nxt;
  end

  assign count      = s_r.cnt;
  assign tc_wait    = s_r.tc_wait;
  assign int_en     = s_r.ctl[`CTCIP_B_IE];
  assign zero_pulse = s_r.zero;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  count_edge_a:
    assert property ((clk_en && s_r.run && s_r.ctl[`CTCIP_B_MODE] && edge_hit && !wr
                      && s_r.cnt > `CTCIP_CNT_LAST) |=> count == $past(s_r.cnt) - 8'h01)
    else $error("counter did not step on active edge");

  zero_reload_a:
    assert property ((clk_en && dec && s_r.cnt == `CTCIP_CNT_LAST && !wr)
                     |=> zero_pulse && count == $past(s_r.tc))
    else $error("zero count without pulse or reload");

  soft_stop_a:
    assert property ((clk_en && wr && !s_r.tc_wait && wr_data[`CTCIP_B_CW]
                      && wr_data[`CTCIP_B_SRST])
                     |=> !s_r.run && int_en == $past(wr_data[`CTCIP_B_IE]))
    else $error("control word not taken");

endmodule // ctcip_chan

/* logic/ctcip_top.sv */
// Bus port, channel select and daisy-chain interrupt logic of the counter/timer
// Operation
// - Channel 0 wins over 1, 2, 3 when several request together.
// - Chain output high only with chain input high and nothing in service.
// - Higher priority may nest over lower; lower blocked until higher finishes.
// - Vector bits 7..3 come from the software-written vector base.
// - Vector bits 2..1 carry the winning channel number in binary.
// - Vector bit 0 is always zero.
// - Interrupt request asserted when an enabled channel reaches zero count.
// - On acknowledge with chain input high, drive the winning channel's vector.
// - Decode return-from-interrupt on fetches; end service, update chain output.
// - Two select inputs pick the channel, upper line is the high bit.
// - I/O request and chip enable with read high is a write.
// - I/O request, chip enable and read low returns the selected down-counter.
// - Reset stops channels, clears enables, outputs idle, chain passes through.
// - Active trigger edge decrements in counter mode, starts timer mode.
// - Channels 0..2 pulse their zero-count output at zero count.
// - All pin inputs are synchronised to the system clock first.
// - Written byte after a control word with bit 2 set is the time constant; else bit 0 set is a control word, else vector base.
// - Zero count raises a request only if bit 7 enabled interrupts.
`timescale 1ns/100ps
`include "ctcip_regs.svh"

module ctcip_top
  import ctcip_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       chip_en_n,
  input  wire logic       io_request_n,
  input  wire logic       rd_n,
  input  wire logic       first_cycle_n,
  input  wire logic       chan_sel_lo,
  input  wire logic       chan_sel_hi,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  input  wire logic       priority_chain_in,
  output logic            priority_chain_out,
  output logic            irq_n_out,
  output logic            irq_oe,
  input  wire logic [3:0] chan_clock_trigger,
  output logic      [2:0] zero_count_pulse
);

  ctcip_top_st_t st_r;
  ctcip_top_st_t st_nxt;

  logic       wr_cyc;
  logic       rd_cyc;
  logic       ack_cyc;
  logic       fetch_cyc;
  logic       ack_go;
  logic       vec_go;
  logic       return_from_irq_instr_go;
  logic [1:0] sel;
  logic [7:0] din;
  logic [2:0] win;
  logic [2:0] win_nxt;
  logic [3:0] clr;
  logic [3:0] set;
  logic [3:0] chan_wr;
  logic [3:0] tcw_w;
  logic [3:0] ie_w;
  logic [3:0] zero_w;
  logic [7:0] cnt_w [4];

  // ****************************************
  // Helpers
  // ****************************************
  // Highest-priority pending channel not masked by a channel in service
  function automatic logic [2:0] ctcip_pick(input logic [3:0] p, input logic [3:0] s);
    logic       blk;
    logic [2:0] r;
    blk = 1'b0;
    r   = 3'h0;
    for (int i = 0; i < 4; i++) begin
      blk = blk | s[i];
      if (!blk && !r[2] && p[i]) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  // One-hot of the lowest set bit
  function automatic logic [3:0] ctcip_lowest(input logic [3:0] v);
    return v & (~v + 4'h1);
  endfunction

  // ****************************************
  // Bus cycle decode
  // ****************************************
  assign din     = st_r.din_s[1];
  assign sel     = {st_r.selhi_s[1], st_r.sello_s[1]};
  assign wr_cyc  = ~st_r.io_request_n_s[1] & ~st_r.ce_s[1] & st_r.rd_s[1] & st_r.m1_s[1];
  assign rd_cyc  = ~st_r.io_request_n_s[1] & ~st_r.ce_s[1] & ~st_r.rd_s[1] & st_r.m1_s[1];
  assign ack_cyc = ~st_r.io_request_n_s[1] & ~st_r.m1_s[1];
  assign fetch_cyc = st_r.io_request_n_s[1] & ~st_r.m1_s[1] & ~st_r.rd_s[1];
  assign win     = ctcip_pick(st_r.pend, st_r.insvc);
  assign ack_go  = ack_cyc & ~st_r.ack_d & st_r.chain_s[1];
  assign vec_go  = wr_cyc & ~st_r.wr_d & ~din[`CTCIP_B_CW] & ~tcw_w[sel];
  assign return_from_irq_instr_go = ~fetch_cyc & st_r.fetch_d & st_r.prev_ed
                   & (st_r.fetch_byte == `CTCIP_RETURN_FROM_IRQ_INSTR_OP) & st_r.chain_s[1];
  assign set     = zero_w & ie_w;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt  = st_r;
    clr     = 4'h0;
    chan_wr = 4'h0;
    win_nxt = 3'h0;
    if (rst || clk_en) begin
      // Two-stage synchronisers on every pin
      st_nxt.io_request_n_s  = {st_r.io_request_n_s[0], io_request_n};
      st_nxt.ce_s    = {st_r.ce_s[0], chip_en_n};
      st_nxt.rd_s    = {st_r.rd_s[0], rd_n};
      st_nxt.m1_s    = {st_r.m1_s[0], first_cycle_n};
      st_nxt.sello_s = {st_r.sello_s[0], chan_sel_lo};
      st_nxt.selhi_s = {st_r.selhi_s[0], chan_sel_hi};
      st_nxt.chain_s = {st_r.chain_s[0], priority_chain_in};
      st_nxt.din_s   = {st_r.din_s[0], data_in};
      if (rst) begin
        // Vector base survives reset
        st_nxt.wr_d       = 1'b0;
        st_nxt.ack_d      = 1'b0;
        st_nxt.fetch_d    = 1'b0;
        st_nxt.fetch_byte = 8'h00;
        st_nxt.prev_ed    = 1'b0;
        st_nxt.pend       = 4'h0;
        st_nxt.insvc      = 4'h0;
        st_nxt.ack_ch     = 2'h0;
        st_nxt.ack_own    = 1'b0;
        st_nxt.dout       = 8'h00;
        st_nxt.doe        = 1'b0;
      end else begin
        st_nxt.wr_d    = wr_cyc;
        st_nxt.ack_d   = ack_cyc;
        st_nxt.fetch_d = fetch_cyc;

        // Register writes
        if (vec_go) begin
          st_nxt.vbase = din[`CTCIP_VEC_HI:`CTCIP_VEC_LO];
        end else if (wr_cyc && !st_r.wr_d) begin
          chan_wr[sel] = 1'b1;
        end

        // Interrupt acknowledge
        if (ack_go && win[2]) begin
          st_nxt.ack_own = 1'b1;
          st_nxt.ack_ch  = win[1:0];
          clr[win[1:0]]  = 1'b1;
        end
        if (!ack_cyc) begin
          st_nxt.ack_own = 1'b0;
        end
        st_nxt.pend  = (st_r.pend & ~clr) | set;
        st_nxt.insvc = st_r.insvc | clr;

        // Return-from-interrupt watch on opcode fetches
        if (fetch_cyc) begin
          st_nxt.fetch_byte = din;
        end
        if (!fetch_cyc && st_r.fetch_d) begin
          st_nxt.prev_ed = (st_r.fetch_byte == `CTCIP_RETURN_FROM_IRQ_INSTR_PFX);
        end
        if (return_from_irq_instr_go) begin
          st_nxt.insvc = st_nxt.insvc & ~ctcip_lowest(st_r.insvc);
        end

        // Data bus
        if (ack_cyc && st_nxt.ack_own) begin
          st_nxt.dout = {st_r.vbase, st_nxt.ack_ch, 1'b0};
          st_nxt.doe  = 1'b1;
        end else if (rd_cyc) begin
          st_nxt.dout = cnt_w[sel];
          st_nxt.doe  = 1'b1;
        end else begin
          st_nxt.dout = 8'h00;
          st_nxt.doe  = 1'b0;
        end
      end

      // Request line and chain output follow the state being loaded
      // Chain input is read only from the second synchroniser stage
      win_nxt          = ctcip_pick(st_nxt.pend, st_nxt.insvc);
      st_nxt.int_oe    = win_nxt[2] & st_r.chain_s[1];
      st_nxt.irq_lvl   = ~st_nxt.int_oe;
      st_nxt.chain_out = st_r.chain_s[1] & (st_nxt.insvc == 4'h0);
    end
  end

  always_ff @(posedge clk_sys) begin
    st_r <= st_nxt;
  end

  // ****************************************
  // Channels
  // ****************************************
  for (genvar g = 0; g < 4; g++) begin : g_chan
    ctcip_chan u_chan (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .clk_en     (clk_en),
      .trig_pin   (chan_clock_trigger[g]),
      .wr         (chan_wr[g]),
      .wr_data    (din),
      .count      (cnt_w[g]),
      .tc_wait    (tcw_w[g]),
      .int_en     (ie_w[g]),
      .zero_pulse (zero_w[g])
    );
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign data_out           = st_r.dout;
  assign data_oe            = st_r.doe;
  assign priority_chain_out = st_r.chain_out;
  assign irq_oe             = st_r.int_oe;
  assign irq_n_out          = st_r.irq_lvl;
  assign zero_count_pulse   = zero_w[2:0];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chain_out_a:
    assert property ($past(clk_en)
                     |-> priority_chain_out == ($past(st_r.chain_s[1]) && st_r.insvc == 4'h0))
    else $error("chain output wrong");

  vec_lsb_a:
    assert property ((data_oe && st_r.ack_own) |-> !data_out[0])
    else $error("odd vector");

  vec_base_a:
    assert property ((data_oe && st_r.ack_own) |-> data_out[7:3] == st_r.vbase)
    else $error("vector base bits wrong");

  vec_code_a:
    assert property ((data_oe && st_r.ack_own) |-> data_out[2:1] == st_r.ack_ch)
    else $error("vector channel code wrong");

  chan_prio_a:
    assert property ((clk_en && ack_go && st_r.pend[0] && st_r.insvc == 4'h0)
                     |=> st_r.insvc[0] && st_r.ack_ch == 2'h0 ##1 data_oe || !ack_cyc)
    else $error("channel 0 not served first");

  nest_block_a:
    assert property ((st_r.insvc[0] && !st_r.pend[0]) |-> !irq_oe)
    else $error("lower request not blocked");

  req_idle_a:
    assert property ((st_r.pend == 4'h0) |-> (!irq_oe && irq_n_out))
    else $error("request without pending channel");

  req_raise_a:
    assert property ((clk_en && set != 4'h0 && st_r.insvc == 4'h0 && st_r.chain_s[1] && !ack_go)
                     |=> irq_oe || !st_r.chain_s[1])
    else $error("zero count did not request");

  return_from_irq_instr_end_a:
    assert property ((clk_en && return_from_irq_instr_go && st_r.insvc[0]) |=> !st_r.insvc[0])
    else $error("return did not end service");

  read_drive_a:
    assert property ((clk_en && rd_cyc) |=> data_oe && !st_r.ack_own)
    else $error("read not answered");

  vec_store_a:
    assert property ((clk_en && vec_go)
                     |=> st_r.vbase == $past(din[`CTCIP_VEC_HI:`CTCIP_VEC_LO]))
    else $error("vector base not stored");

endmodule // ctcip_top

/* pkg/ctcip_pkg.sv */
// Types of the counter/timer interrupt port
package ctcip_pkg;

  typedef struct packed {
    logic       trig_s1;
    logic       trig_s2;
    logic       trig_d;
    logic [7:0] ctl;
    logic [7:0] tc;
    logic [7:0] cnt;
    logic [7:0] pre;
    logic       run;
    logic       arm;
    logic       tc_wait;
    logic       zero;
  } ctcip_chan_st_t;

  typedef struct packed {
    logic [1:0] io_request_n_s;
    logic [1:0] ce_s;
    logic [1:0] rd_s;
    logic [1:0] m1_s;
    logic [1:0] sello_s;
    logic [1:0] selhi_s;
    logic [1:0] chain_s;
    logic [1:0][7:0] din_s;
    logic       wr_d;
    logic       ack_d;
    logic       fetch_d;
    logic [7:0] fetch_byte;
    logic       prev_ed;
    logic [4:0] vbase;
    logic [3:0] pend;
    logic [3:0] insvc;
    logic [1:0] ack_ch;
    logic       ack_own;
    logic [7:0] dout;
    logic       doe;
    logic       int_oe;
    logic       irq_lvl;
    logic       chain_out;
  } ctcip_top_st_t;

endpackage

/* pkg/ctcip_regs.svh */
// Bit positions, codes and counts of the counter/timer interrupt port
`ifndef CTCIP_REGS_SVH
`define CTCIP_REGS_SVH

// Channel control word fields
`define CTCIP_B_IE    3'h7
`define CTCIP_B_MODE  3'h6
`define CTCIP_B_PRE   3'h5
`define CTCIP_B_EDGE  3'h4
`define CTCIP_B_TRIG  3'h3
`define CTCIP_B_TCF   3'h2
`define CTCIP_B_SRST  3'h1
`define CTCIP_B_CW    3'h0
`define CTCIP_CTL_RST 8'h00

// Vector layout
`define CTCIP_VEC_HI  3'h7
`define CTCIP_VEC_LO  3'h3

// Return-from-interrupt opcode pair
`define CTCIP_RETURN_FROM_IRQ_INSTR_PFX 8'hed
`define CTCIP_RETURN_FROM_IRQ_INSTR_OP  8'h4d

// Prescaler terminal counts and down-counter reload point
`define CTCIP_PRE16_END  8'h0f
`define CTCIP_PRE256_END 8'hff
`define CTCIP_CNT_LAST   8'h01

`endif

/* testbench/ctcip_cpu_model.sv */
// Processor bus model: I/O write, I/O read, interrupt acknowledge, opcode fetch
`timescale 1ns/100ps

module ctcip_cpu_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic            chip_en_n,
  output logic            io_request_n,
  output logic            rd_n,
  output logic            first_cycle_n,
  output logic            chan_sel_lo,
  output logic            chan_sel_hi,
  output logic      [7:0] data_in
);
  initial begin
    {chip_en_n, io_request_n, rd_n, first_cycle_n} = 4'hf;
    {chan_sel_hi, chan_sel_lo} = 2'h0;
    data_in = 8'h5a;
  end

  // One bus cycle; pins = {chip_en_n, io_request_n, rd_n, first_cycle_n}
  // Strobes held six cycles, well past the synchroniser latency
  task automatic cycle(input logic [3:0] pins, input logic [1:0] sel,
                       input logic [7:0] wd, output logic [7:0] rdat, output logic roe);
    @(negedge clk_sys);
    {chan_sel_hi, chan_sel_lo} = sel;
    data_in = wd;
    @(negedge clk_sys);
    {chip_en_n, io_request_n, rd_n, first_cycle_n} = pins;
    repeat (6) @(negedge clk_sys);
    rdat = data_out;
    roe = data_oe;
    {chip_en_n, io_request_n, rd_n, first_cycle_n} = 4'hf;
    repeat (2) @(negedge clk_sys);
    // Released bus shows no stale byte
    data_in = ~wd;
    repeat (4) @(negedge clk_sys);
  endtask
endmodule // ctcip_cpu_model

/* testbench/ctcip_tb_top.sv */
// Self-checking bench of the counter/timer bus port and interrupt chain
`timescale 1ns/100ps
`include "ctcip_regs.svh"
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("MISMATCH %s expected %h seen %h", nm, e, g); \
    end \
  end

module ctcip_tb_top;
  typedef struct packed {
    logic [1:0] ch;
    logic [7:0] tc;
  } ctcip_row_t;

  localparam logic [3:0] WR_P  = 4'h3;
  localparam logic [3:0] RD_P  = 4'h1;
  localparam logic [3:0] ACK_P = 4'ha;
  localparam logic [3:0] FE_P  = 4'hc;
  localparam logic [7:0] VBASE = 8'hae;

  logic       clk_sys, rst, clk_en, chip_en_n, io_request_n, rd_n, first_cycle_n;
  logic       chan_sel_lo, chan_sel_hi, data_oe, priority_chain_in, priority_chain_out;
  logic       irq_n_out, irq_oe, ro;
  logic [7:0] data_in, data_out, rv;
  logic [3:0] chan_clock_trigger;
  logic [2:0] zero_count_pulse;
  int         failures = 0;
  int         num_checks = 0;
  int         zc_cnt [3] = '{0, 0, 0};
  ctcip_row_t rows [4] = '{'{2'h0, 8'h02}, '{2'h1, 8'h03}, '{2'h2, 8'h04}, '{2'h3, 8'h01}};

  ctcip_top u_ctcip_top (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
    .chip_en_n(chip_en_n), .io_request_n(io_request_n), .rd_n(rd_n),
    .first_cycle_n(first_cycle_n), .chan_sel_lo(chan_sel_lo), .chan_sel_hi(chan_sel_hi),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .priority_chain_in(priority_chain_in), .priority_chain_out(priority_chain_out),
    .irq_n_out(irq_n_out), .irq_oe(irq_oe), .chan_clock_trigger(chan_clock_trigger),
    .zero_count_pulse(zero_count_pulse));

  ctcip_cpu_model u_ctcip_cpu_model (.clk_sys(clk_sys), .data_out(data_out),
    .data_oe(data_oe), .chip_en_n(chip_en_n), .io_request_n(io_request_n), .rd_n(rd_n),
    .first_cycle_n(first_cycle_n), .chan_sel_lo(chan_sel_lo), .chan_sel_hi(chan_sel_hi),
    .data_in(data_in));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    for (int i = 0; i < 3; i++) begin
      if (zero_count_pulse[i] === 1'b1) zc_cnt[i]++;
    end
  end

  function automatic logic [7:0] vec(input logic [1:0] ch);
    return {VBASE[7:3], ch, 1'b0};
  endfunction

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [1:0] ch, input logic [7:0] d);
    u_ctcip_cpu_model.cycle(WR_P, ch, d, rv, ro);
  endtask

  task automatic rd_chk(input logic [1:0] ch, input logic [7:0] e);
    u_ctcip_cpu_model.cycle(RD_P, ch, 8'h00, rv, ro);
    `CHK("read drive", 1'b1, ro)
    `CHK("read data", e, rv)
  endtask

  task automatic ack_chk(input logic e_oe, input logic [7:0] e);
    u_ctcip_cpu_model.cycle(ACK_P, 2'h0, 8'h00, rv, ro);
    `CHK("ack drive", e_oe, ro)
    if (e_oe) `CHK("vector", e, rv)
  endtask

  task automatic return_from_irq_instr();
    u_ctcip_cpu_model.cycle(FE_P, 2'h0, `CTCIP_RETURN_FROM_IRQ_INSTR_PFX, rv, ro);
    u_ctcip_cpu_model.cycle(FE_P, 2'h0, `CTCIP_RETURN_FROM_IRQ_INSTR_OP, rv, ro);
  endtask

  task automatic trig(input logic [3:0] m, input int n);
    repeat (n) begin
      @(negedge clk_sys);
      chan_clock_trigger = m;
      repeat (4) @(negedge clk_sys);
      chan_clock_trigger = 4'h0;
      repeat (3) @(negedge clk_sys);
    end
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic do_reset();
    @(negedge clk_sys);
    rst = 1'b1;
    repeat (16) @(negedge clk_sys);
    `CHK("reset drive", 1'b0, data_oe)
    `CHK("reset request", 1'b0, irq_oe)
    `CHK("reset request pin", 1'b1, irq_n_out)
    `CHK("reset zero pulse", 3'h0, zero_count_pulse)
    `CHK("reset chain", priority_chain_in, priority_chain_out)
    rst = 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    summarize();
  end

  initial begin
    {rst, clk_en, priority_chain_in, chan_clock_trigger} = {1'b1, 1'b1, 1'b1, 4'h0};
    do_reset();
    wr(2'h2, VBASE);
    foreach (rows[i]) begin
      wr(rows[i].ch, 8'hd7);
      wr(rows[i].ch, rows[i].tc);
      rd_chk(rows[i].ch, rows[i].tc);
    end
    // ************************************************************
    // Nested service and blocking
    // ************************************************************
    trig(4'h8, 1);
    `CHK("request", 1'b1, irq_oe)
    `CHK("request pin", 1'b0, irq_n_out)
    ack_chk(1'b1, vec(2'h3));
    `CHK("chain blocked", 1'b0, priority_chain_out)
    `CHK("request released", 1'b0, irq_oe)
    trig(4'h1, 2);
    `CHK("nested request", 1'b1, irq_oe)
    ack_chk(1'b1, vec(2'h0));
    trig(4'h2, 3);
    `CHK("lower blocked", 1'b0, irq_oe)
    return_from_irq_instr();
    `CHK("lower unblocked", 1'b1, irq_oe)
    ack_chk(1'b1, vec(2'h1));
    return_from_irq_instr();
    `CHK("chain held", 1'b0, priority_chain_out)
    return_from_irq_instr();
    `CHK("chain restored", 1'b1, priority_chain_out)
    // ************************************************************
    // Counting, simultaneous requests, chain input low
    // ************************************************************
    trig(4'h4, 1);
    rd_chk(2'h2, 8'h03);
    trig(4'h6, 3);
    priority_chain_in = 1'b0;
    repeat (4) @(negedge clk_sys);
    `CHK("chain follows input", 1'b0, priority_chain_out)
    ack_chk(1'b0, 8'h00);
    priority_chain_in = 1'b1;
    ack_chk(1'b1, vec(2'h1));
    return_from_irq_instr();
    ack_chk(1'b1, vec(2'h2));
    return_from_irq_instr();
    // ************************************************************
    // Reset keeps vector base; disabled channel stays silent
    // ************************************************************
    do_reset();
    wr(2'h0, 8'h57);
    wr(2'h0, 8'h01);
    trig(4'h1, 1);
    `CHK("disabled channel", 1'b0, irq_oe)
    wr(2'h3, 8'hd7);
    wr(2'h3, 8'h01);
    trig(4'h8, 1);
    ack_chk(1'b1, vec(2'h3));
    // ************************************************************
    // Falling-edge counter; trigger-started timer, prescaler 16
    // ************************************************************
    wr(2'h2, 8'h47);
    wr(2'h2, 8'h02);
    trig(4'h4, 1);
    rd_chk(2'h2, 8'h01);
    wr(2'h1, 8'h1f);
    wr(2'h1, 8'h02);
    repeat (40) @(negedge clk_sys);
    `CHK("timer armed", 2, zc_cnt[1])
    trig(4'h2, 1);
    repeat (30) @(negedge clk_sys);
    `CHK("timer pulse", 3, zc_cnt[1])
    wr(2'h1, 8'h03);
    `CHK("zero pulses ch0", 2, zc_cnt[0])
    `CHK("zero pulses ch1", 3, zc_cnt[1])
    `CHK("zero pulses ch2", 1, zc_cnt[2])
    summarize();
  end
endmodule // ctcip_tb_top
